/* inc/rst_seq_pkg.sv */
// Shared constants for the reset and watchdog sequencer and its host controller
package rst_seq_pkg;
   // Clock
   localparam real CLK_HZ = 250.0e6;
   // Power-on delay, printed as 0.75 s; least time, so rounded up
   localparam real POR_DELAY_S = 0.75;
   localparam int unsigned POR_DELAY_CYC = int'($ceil(POR_DELAY_S * CLK_HZ));
   // Watchdog period, a plain default of 100 ms
   localparam real WD_PERIOD_S = 0.1;
   localparam int unsigned WD_PERIOD_CYC = int'($ceil(WD_PERIOD_S * CLK_HZ));
   // Reset pulse width, a plain default of 1 us (250 cycles)
   localparam real RST_PULSE_S = 1.0e-6;
   localparam int unsigned RST_PULSE_CYC = int'($ceil(RST_PULSE_S * CLK_HZ));
   localparam int CNT_W = 32;
   // Device I/O map
   localparam int IO_AW = 16;
   localparam logic [IO_AW-1:0] RESET_INIT_CONTROL_ADDR = 16'h0000;
   // Bit layout of reset_init_control
   localparam int HOST_FULL_RESET_BIT = 7;
   localparam int DIGITAL_OUT_VALID_BIT = 6;
   localparam int MUTE_N_BIT = 5;
   localparam int DIGITAL_IO_RESET_N_BIT = 4;
   localparam int FORCED_BOOT_MODE_BIT = 3;
   localparam int SIGNAL_PROC_RESET_N_BIT = 2;
   localparam int EFFECTS_CHIP_RESET_N_BIT = 1;
   localparam int SLAVE_CPU_RESET_N_BIT = 0;
   localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
   // Controller AXI4-Lite map
   localparam logic [3:0] AXI_CTRL_OFS = 4'h0;
   localparam logic [3:0] AXI_KICK_OFS = 4'h4;
   localparam logic [3:0] AXI_STAT_OFS = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states
   typedef enum logic [1:0]
   {
      ST_PULSE = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN = 2'b10
   } seq_state_e;
endpackage

/* inc/rst_link_if.sv */
// Link between the host controller and the reset sequencer
`timescale 1ns/1ps
interface rst_link_if;
   import rst_seq_pkg::*;
   logic io_wr;
   logic [IO_AW-1:0] io_addr;
   logic [7:0] io_wdata;
   logic wd_kick;
   logic host_reset_n;
   modport dev
   (
      input io_wr,
      input io_addr,
      input io_wdata,
      input wd_kick,
      output host_reset_n
   );
   modport host
   (
      output io_wr,
      output io_addr,
      output io_wdata,
      output wd_kick,
      input host_reset_n
   );
endinterface

/* hdl/system_reset_watchdog_sequencer.sv */
// Device end: supply monitor, reset pulse, power-on delay, watchdog, reset control register
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module system_reset_watchdog_sequencer
   import rst_seq_pkg::*;
#(
   parameter int unsigned POR_CYC = POR_DELAY_CYC,
   parameter int unsigned WD_CYC = WD_PERIOD_CYC
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   rst_link_if.dev link,
   input wire logic supply_ok_i,
   output logic system_reset_n_o,
   output logic uart_reset_n_o,
   output logic digital_out_valid_o,
   output logic mute_n_o,
   output logic digital_io_reset_n_o,
   output logic forced_boot_mode_o,
   output logic signal_proc_reset_n_o,
   output logic effects_chip_reset_n_o,
   output logic slave_cpu_reset_n_o,
   output logic watchdog_armed_o
);
   localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
   localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYC - 1);
   localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(RST_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic sup_s1;
   logic sup_s2;
   logic supply_low;
   seq_state_e state;
   logic [CNT_W-1:0] seq_cnt;
   logic [7:0] ctrl;
   logic full_reset_q;
   logic full_reset_rise;
   logic wd_armed;
   logic [CNT_W-1:0] wd_cnt;
   logic wd_fall;
   logic running;
   logic ctrl_wr;

   // Supply level is a pin, so two flops before anything looks at it
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sup_s1 <= 1'b0;
         sup_s2 <= 1'b0;
      end
      else
      begin
         sup_s1 <= supply_ok_i;
         sup_s2 <= sup_s1;
      end
   end

   assign supply_low = !sup_s2;
   assign running = (state == ST_RUN);
   assign full_reset_rise = ctrl[HOST_FULL_RESET_BIT] && !full_reset_q;
   // Watchdog first stage output falls when an armed count runs out
   assign wd_fall = running && wd_armed && (wd_cnt == '0) && !link.wd_kick;
   // Register writes are only taken while the unit is out of reset
   assign ctrl_wr = running && link.io_wr
      && (link.io_addr == RESET_INIT_CONTROL_ADDR);

   // Reset pulse stage and power-on delay stage share one counter
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= ST_PULSE;
         seq_cnt <= '0;
      end
      else if (supply_low)
      begin
         // Low supply holds the pulse stage, no early warning given
         state <= ST_PULSE;
         seq_cnt <= '0;
      end
      else
      begin
         case (state)
            ST_PULSE:
            begin
               if (seq_cnt >= PULSE_LAST)
               begin
                  state <= ST_DELAY;
                  seq_cnt <= '0;
               end
               else
               begin
                  seq_cnt <= seq_cnt + CNT_ONE;
               end
            end
            ST_DELAY:
            begin
               if (seq_cnt >= POR_LAST)
               begin
                  state <= ST_RUN;
                  seq_cnt <= '0;
               end
               else
               begin
                  seq_cnt <= seq_cnt + CNT_ONE;
               end
            end
            ST_RUN:
            begin
               if (wd_fall || full_reset_rise)
               begin
                  state <= ST_PULSE;
                  seq_cnt <= '0;
               end
            end
            default:
            begin
               state <= ST_PULSE;
               seq_cnt <= '0;
            end
         endcase
      end
   end

   // Edge memory for the full-reset bit
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         full_reset_q <= 1'b0;
      end
      else
      begin
         full_reset_q <= ctrl[HOST_FULL_RESET_BIT];
      end
   end

   // Reset control register, held cleared whenever the unit is in reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl <= CTRL_RESET_VAL;
      end
      else if (!running)
      begin
         // Clearing here also drops the full-reset bit, so no latch-up
         ctrl <= CTRL_RESET_VAL;
      end
      else if (ctrl_wr)
      begin
         ctrl <= link.io_wdata;
      end
   end

   // Watchdog: idle until the first kick, each kick reloads the period
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wd_armed <= 1'b0;
         wd_cnt <= '0;
      end
      else if (!running)
      begin
         wd_armed <= 1'b0;
         wd_cnt <= '0;
      end
      else if (link.wd_kick)
      begin
         wd_armed <= 1'b1;
         wd_cnt <= WD_LAST;
      end
      else if (wd_armed)
      begin
         if (wd_cnt == '0)
         begin
            wd_armed <= 1'b0;
         end
         else
         begin
            wd_cnt <= wd_cnt - CNT_ONE;
         end
      end
   end

   // Reset outputs follow the sequencer state
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         system_reset_n_o <= 1'b0;
         uart_reset_n_o <= 1'b0;
         link.host_reset_n <= 1'b0;
      end
      else
      begin
         system_reset_n_o <= running && !supply_low;
         uart_reset_n_o <= running && !supply_low;
         link.host_reset_n <= running && !supply_low;
      end
   end

   // Register fields drive the subsystem pins straight from the flops
   assign digital_out_valid_o = ctrl[DIGITAL_OUT_VALID_BIT];
   assign mute_n_o = ctrl[MUTE_N_BIT];
   assign digital_io_reset_n_o = ctrl[DIGITAL_IO_RESET_N_BIT];
   assign forced_boot_mode_o = ctrl[FORCED_BOOT_MODE_BIT];
   assign signal_proc_reset_n_o = ctrl[SIGNAL_PROC_RESET_N_BIT];
   assign effects_chip_reset_n_o = ctrl[EFFECTS_CHIP_RESET_N_BIT];
   assign slave_cpu_reset_n_o = ctrl[SLAVE_CPU_RESET_N_BIT];
   assign watchdog_armed_o = wd_armed;
endmodule

/* hdl/reset_host_controller.sv */
// Host end: AXI4-Lite command registers that write the reset control register and kick
`timescale 1ns/1ps
module reset_host_controller
   import rst_seq_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   rst_link_if.host link,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic aw_got;
   logic w_got;
   logic [3:0] aw_ofs;
   logic [7:0] w_byte;
   logic w_lane0;
   logic do_wr;
   logic [7:0] shadow;
   logic boot_clear_pend;
   logic [7:0] next_ctrl;

   // Word offset decode, shared by both paths
   function automatic logic [3:0] word_ofs(input logic [31:0] a);
      word_ofs = {a[3:2], 2'b00};
   endfunction

   assign s_axi_awready = !aw_got && !s_axi_bvalid;
   assign s_axi_wready = !w_got && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_wr = aw_got && w_got && !s_axi_bvalid;

   // Releasing the processor reset forces boot mode on in the same write
   always_comb
   begin
      next_ctrl = w_byte;
      if (w_byte[SIGNAL_PROC_RESET_N_BIT] && !shadow[SIGNAL_PROC_RESET_N_BIT])
      begin
         next_ctrl[FORCED_BOOT_MODE_BIT] = 1'b1;
      end
   end

   // Address and data are caught in either order
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_ofs <= 4'h0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_ofs <= word_ofs(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_wr)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_ofs == AXI_STAT_OFS) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Link strobes; nothing goes out while the host itself is held in reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         link.io_wr <= 1'b0;
         link.io_addr <= RESET_INIT_CONTROL_ADDR;
         link.io_wdata <= CTRL_RESET_VAL;
         link.wd_kick <= 1'b0;
         shadow <= CTRL_RESET_VAL;
         boot_clear_pend <= 1'b0;
      end
      else
      begin
         link.io_wr <= 1'b0;
         link.wd_kick <= 1'b0;
         if (!link.host_reset_n)
         begin
            // Device clears its register during reset; mirror that
            shadow <= CTRL_RESET_VAL;
            boot_clear_pend <= 1'b0;
         end
         else if (do_wr && w_lane0 && aw_ofs == AXI_CTRL_OFS)
         begin
            link.io_wr <= 1'b1;
            link.io_wdata <= next_ctrl;
            shadow <= next_ctrl;
            boot_clear_pend <= next_ctrl[FORCED_BOOT_MODE_BIT]
               && !shadow[SIGNAL_PROC_RESET_N_BIT]
               && next_ctrl[SIGNAL_PROC_RESET_N_BIT];
         end
         else if (do_wr && aw_ofs == AXI_KICK_OFS)
         begin
            link.wd_kick <= 1'b1;
         end
         else if (boot_clear_pend)
         begin
            // Follow-up write drops boot mode once the processor is running
            link.io_wr <= 1'b1;
            link.io_wdata <= shadow & ~(8'h01 << FORCED_BOOT_MODE_BIT);
            shadow <= shadow & ~(8'h01 << FORCED_BOOT_MODE_BIT);
            boot_clear_pend <= 1'b0;
         end
      end
   end

   // Reads answer one cycle after the address is taken
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (word_ofs(s_axi_araddr))
            AXI_CTRL_OFS: s_axi_rdata <= {24'h000000, shadow};
            AXI_STAT_OFS: s_axi_rdata <= {30'h0, boot_clear_pend, link.host_reset_n};
            AXI_KICK_OFS: s_axi_rdata <= 32'h0000_0000;
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* verification/rst_link_checker.sv */
// Assertion checker watching the reset link between host controller and sequencer
`timescale 1ns/1ps
module rst_link_checker
   import rst_seq_pkg::*;
#(
   parameter int unsigned POR_CYC = POR_DELAY_CYC,
   parameter int unsigned WD_CYC = WD_PERIOD_CYC
)
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic io_wr,
   input wire logic [IO_AW-1:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic wd_kick,
   input wire logic host_reset_n
);
   int unsigned low_cnt;
   int unsigned idle_cnt;
   logic armed;
   logic proc_up;
   default clocking dcb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Cycles the host has been held in reset, to bound the release delay
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         low_cnt <= 0;
      else if (host_reset_n)
         low_cnt <= 0;
      else
         low_cnt <= low_cnt + 1;
   end

   // Watchdog as seen on the link; any reset disarms it, so a stale kick never counts
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         armed <= 1'b0;
      else
         armed <= host_reset_n && (armed || wd_kick);
   end

   // Cycles since the last kick
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         idle_cnt <= 0;
      else if (wd_kick)
         idle_cnt <= 0;
      else
         idle_cnt <= idle_cnt + 1;
   end

   // Last processor reset level sent; the register is cleared in reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         proc_up <= 1'b0;
      else if (!host_reset_n)
         proc_up <= 1'b0;
      else if (io_wr)
         proc_up <= io_wdata[SIGNAL_PROC_RESET_N_BIT];
   end

   sequence s_proc_raise;
      io_wr && host_reset_n && io_wdata[SIGNAL_PROC_RESET_N_BIT] && !proc_up;
   endsequence
   sequence s_boot_drop;
      io_wr && io_wdata[SIGNAL_PROC_RESET_N_BIT] && !io_wdata[FORCED_BOOT_MODE_BIT];
   endsequence

   property p_io_at_zero;
      io_wr |-> io_addr == RESET_INIT_CONTROL_ADDR;
   endproperty
   a_io_at_zero: assert property (p_io_at_zero) else $error("link write off location zero");
   property p_kick_single;
      wd_kick |=> !wd_kick;
   endproperty
   a_kick_single: assert property (p_kick_single) else $error("kick longer than one cycle");
   property p_full_reset;
      io_wr && host_reset_n && io_wdata[HOST_FULL_RESET_BIT] |-> ##[1:5] !host_reset_n;
   endproperty
   a_full_reset: assert property (p_full_reset) else $error("full reset bit ignored");
   property p_por_delay;
      $rose(host_reset_n) |-> low_cnt >= RST_PULSE_CYC + POR_CYC - 1;
   endproperty
   a_por_delay: assert property (p_por_delay) else $error("host released too early");
   property p_wd_timeout;
      armed && idle_cnt == WD_CYC |-> ##[0:6] !host_reset_n;
   endproperty
   a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog did not expire");
   property p_boot_set;
      s_proc_raise |-> io_wdata[FORCED_BOOT_MODE_BIT];
   endproperty
   a_boot_set: assert property (p_boot_set) else $error("boot mode low at release");
   property p_boot_clear;
      s_proc_raise |-> ##[1:3] s_boot_drop;
   endproperty
   a_boot_clear: assert property (p_boot_clear) else $error("boot mode not cleared");
   property p_stay_low;
      $fell(host_reset_n) |=> !host_reset_n [*8];
   endproperty
   a_stay_low: assert property (p_stay_low) else $error("reset pulse too short");
   property p_quiet;
      !host_reset_n && !$past(host_reset_n) |-> !io_wr && !wd_kick;
   endproperty
   a_quiet: assert property (p_quiet) else $error("link active in reset");
endmodule

/* verification/system_reset_watchdog_sequencer_bench.sv */
// Testbench joining the host controller and the sequencer through the reset link
`timescale 1ns/1ps
module system_reset_watchdog_sequencer_bench;
   import rst_seq_pkg::*;
   localparam int unsigned POR = 20;
   localparam int unsigned WD = 50;
   localparam int REL = RST_PULSE_CYC + POR;
   logic clk, rst_n, supply_ok;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] awaddr, wdata, araddr, seed;
   logic [3:0] wstrb;
   wire awready, wready, bvalid, arready, rvalid, sys_n, uart_n, wd_on;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [6:0] regs;
   int fails, tests_run, n, i, cyc_cnt;
   logic [7:0] v, prev;

   rst_link_if link ();
   system_reset_watchdog_sequencer #(.POR_CYC(POR), .WD_CYC(WD))
      system_reset_watchdog_sequencer_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .link(link),
      .supply_ok_i(supply_ok), .system_reset_n_o(sys_n), .uart_reset_n_o(uart_n),
      .digital_out_valid_o(regs[6]), .mute_n_o(regs[5]), .digital_io_reset_n_o(regs[4]),
      .forced_boot_mode_o(regs[3]), .signal_proc_reset_n_o(regs[2]),
      .effects_chip_reset_n_o(regs[1]), .slave_cpu_reset_n_o(regs[0]), .watchdog_armed_o(wd_on));
   reset_host_controller reset_host_controller_inst (.sys_clk_i(clk), .rst_n_i(rst_n),
      .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   rst_link_checker #(.POR_CYC(POR), .WD_CYC(WD)) rst_link_checker_inst (.sys_clk_i(clk),
      .rst_n_i(rst_n), .io_wr(link.io_wr), .io_addr(link.io_addr), .io_wdata(link.io_wdata),
      .wd_kick(link.wd_kick), .host_reset_n(link.host_reset_n));

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic test_done();
      begin
         $display("Checks %0d, mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // Cut a hang short; the whole run needs under two thousand cycles
   always @(posedge clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         fails++;
         $display("ERROR timeout expected end seen hang");
         test_done();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         tests_run++;
         if (got !== exp)
         begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   function automatic logic [7:0] nxt();
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         return seed[7:0];
      end
   endfunction

   // Raising the processor reset also brings the boot bit back low a cycle later
   function automatic logic [6:0] exp_regs(input logic [7:0] old, input logic [7:0] nv);
      begin
         exp_regs = nv[6:0];
         if (nv[2] && !old[2])
            exp_regs[3] = 1'b0;
      end
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   // Counts negedges until the master reset reaches a level
   task automatic wait_lvl(input logic lvl, output int cnt);
      begin
         cnt = 0;
         while (sys_n !== lvl)
         begin
            @(negedge clk);
            cnt++;
         end
      end
   endtask

   // One AXI4-Lite write or read; handshakes sampled mid-cycle, signals moved at the edge
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic a_hs, w_hs, done;
      logic [1:0] resp;
      logic [31:0] rd;
      begin
         @(posedge clk);
         awaddr <= {28'h0, a};
         araddr <= {28'h0, a};
         wdata <= d;
         awvalid <= wr;
         wvalid <= wr;
         bready <= wr;
         arvalid <= !wr;
         rready <= !wr;
         do
         begin
            @(negedge clk);
            a_hs = wr ? awvalid && awready : arvalid && arready;
            w_hs = wvalid && wready;
            done = wr ? bvalid : rvalid;
            resp = wr ? bresp : rresp;
            rd = rdata;
            @(posedge clk);
            if (a_hs)
               awvalid <= 1'b0;
            if (a_hs)
               arvalid <= 1'b0;
            if (w_hs)
               wvalid <= 1'b0;
         end
         while (done !== 1'b1);
         bready <= 1'b0;
         rready <= 1'b0;
         chk("resp", er, resp);
         if (!wr)
            chk("rdata", d, rd);
      end
   endtask

   // Main sequence
   initial
   begin
      seed = 32'hD72A;
      rst_n = 1'b0;
      supply_ok = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = {3{32'h0}};
      wstrb = 4'hF;
      prev = 8'h00;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("regs", 7'h00, regs);
      wait_lvl(1'b1, n);
      chk("release", 1, n >= REL && n <= REL + 8);
      chk("uart", 1'b1, uart_n);
      chk("host", 1'b1, link.host_reset_n);
      chk("regs", 7'h00, regs);
      axi(1'b0, 4'h8, 32'h1, RESP_OKAY);
      axi(1'b0, 4'hC, 32'h0, RESP_SLVERR);
      axi(1'b1, 4'h8, 32'h80, RESP_SLVERR);
      cyc(3 * WD);
      chk("idle", 2'b01, {wd_on, sys_n});
      for (i = 0; i < 14; i++)
      begin
         v = (i < 2) ? (i ? 8'h7F : 8'h04) : (nxt() & 8'h7F);
         axi(1'b1, 4'h0, {24'h0, v}, RESP_OKAY);
         cyc(4);
         chk("regs", exp_regs(prev, v), regs);
         // Track what the register should hold, boot bit already dropped
         prev = {1'b0, exp_regs(prev, v)};
      end
      axi(1'b0, 4'h0, {24'h0, prev}, RESP_OKAY);
      // Low byte lane off: the write is answered but never reaches the link
      wstrb <= 4'hE;
      axi(1'b1, 4'h0, 32'h0, RESP_OKAY);
      wstrb <= 4'hF;
      cyc(4);
      chk("lane", prev[6:0], regs);
      axi(1'b1, 4'h4, 32'h0, RESP_OKAY);
      cyc(2);
      chk("armed", 1'b1, wd_on);
      repeat (6)
      begin
         cyc(WD / 2);
         axi(1'b1, 4'h4, nxt(), RESP_OKAY);
      end
      chk("kicked", 1'b1, sys_n);
      wait_lvl(1'b0, n);
      chk("timeout", 1, n >= WD - 8 && n <= WD + 8);
      wait_lvl(1'b1, n);
      chk("rerun", 1, n >= REL);
      chk("regs", 2'b00, {wd_on, regs[2]});
      axi(1'b1, 4'h0, 32'h35, RESP_OKAY);
      axi(1'b1, 4'h0, 32'hB5, RESP_OKAY);
      wait_lvl(1'b0, n);
      chk("full", 1, n <= 8);
      axi(1'b1, 4'h0, 32'h7F, RESP_OKAY);
      axi(1'b1, 4'h4, 32'h0, RESP_OKAY);
      wait_lvl(1'b1, n);
      chk("full", 1, n >= REL - 10);
      chk("regs", 8'h00, {wd_on, regs});
      @(posedge clk);
      supply_ok <= 1'b0;
      wait_lvl(1'b0, n);
      chk("supply", 1, n <= 4);
      cyc(40);
      chk("held", 1'b0, sys_n);
      @(posedge clk);
      supply_ok <= 1'b1;
      wait_lvl(1'b1, n);
      chk("supply", 1, n >= REL);
      test_done();
   end
endmodule
